/* core/flcs_top.v */
// Fuse, lock and calibration store of a small microcontroller.
// Assumes all inputs synchronous to ref_clk_i; arrays live outside.
`timescale 1ns/10ps
`default_nettype none
`include "flcs_defs.vh"
module flcs_top #(
  parameter       FLASH_AW = `FLCS_FLASH_TOP + 1,
  parameter       EE_AW    = `FLCS_EE_TOP + 1,
  parameter [7:0] SIG0     = 8'hA5, // Arbitrary identity value
  parameter [7:0] SIG1     = 8'h5A, // Arbitrary identity value
  parameter [7:0] SIG2     = 8'h3C, // Arbitrary identity value
  parameter [7:0] CAL_9M6  = 8'h80,
  parameter [7:0] CAL_4M8  = 8'h80
) (
  input  wire                ref_clk_i,
  input  wire                resetn_i,
  input  wire                clk_en_i,
  input  wire                prog_mode_i,
  input  wire                prog_serial_i,
  input  wire                cmd_valid_i,
  input  wire [2:0]          cmd_op_i,
  input  wire [1:0]          cmd_addr_i,
  input  wire [7:0]          cmd_data_i,
  input  wire                fuse_read_request_i,
  input  wire                self_program_enable_i,
  input  wire                program_memory_load_instr_i,
  input  wire [15:0]         fw_z_addr_i,
  input  wire                cal_wr_i,
  input  wire [7:0]          cal_data_i,
  input  wire [FLASH_AW-1:0] flash_addr_i,
  input  wire [EE_AW-1:0]    eeprom_addr_i,
  output reg                 rsp_valid_o,
  output reg  [7:0]          rsp_data_o,
  output reg                 cmd_refused_o,
  output reg                 flash_erase_o,
  output reg                 eeprom_erase_o,
  output reg  [7:0]          erase_fill_o,
  output reg                 array_write_allow_o,
  output reg                 array_verify_allow_o,
  output reg                 debug_if_enable_o,
  output reg                 debug_flash_read_o,
  output reg                 watchdog_irq_allow_o,
  output reg                 self_program_enable_o,
  output reg  [1:0]          brownout_level_o,
  output reg                 ext_reset_disable_o,
  output reg                 serial_prog_enable_o,
  output reg                 eeprom_preserve_o,
  output reg                 watchdog_always_on_o,
  output reg                 clock_divide_by_eight_o,
  output reg  [1:0]          startup_time_o,
  output reg  [1:0]          clock_source_o,
  output reg  [7:0]          oscillator_calibration_reg_o,
  output wire                fw_read_armed_o,
  output wire                fw_read_valid_o,
  output wire [7:0]          fw_read_data_o,
  output reg  [3:0]          flash_word_in_page_o,
  output reg  [4:0]          flash_page_number_o,
  output reg  [1:0]          eeprom_byte_in_page_o,
  output reg  [3:0]          eeprom_page_number_o
);
  // ----------------------------------------
  // Stored and latched state
  // ----------------------------------------
  reg  [1:0] lock_bits;
  reg  [7:0] fuse_low;
  reg  [7:0] fuse_high;
  reg  [7:0] fl_lat;
  reg  [7:0] fh_lat;
  reg        prog_mode_q;
  reg        boot_pending;
  wire [7:0] lock_byte;
  wire       lock_bit_low;
  wire       lock_bit_high;
  wire       mode_free;
  wire       latch_now;
  wire       cmd_go;
  wire       rom_space;
  wire [7:0] rom_data;
  wire       rom_hit;
  wire       fw_arm;

  assign lock_byte     = {`FLCS_LOCK_PAD, lock_bits};
  assign lock_bit_low  = lock_bits[`FLCS_LOCK_LO];
  assign lock_bit_high = lock_bits[`FLCS_LOCK_HI];
  assign mode_free     = (lock_bits == `FLCS_LOCK_RST);
  // Power-up in normal mode, or any edge of programming mode
  assign latch_now = (boot_pending && !prog_mode_i)
                   || (prog_mode_i != prog_mode_q);
  assign cmd_go    = cmd_valid_i && prog_mode_i;
  assign fw_arm    = fuse_read_request_i && self_program_enable_i;
  // During boot the ROM is steered to the 9.6 MHz byte
  assign rom_space = boot_pending ? `FLCS_SP_CAL
                   : (cmd_op_i == `FLCS_OP_RD_CAL);
  // ----------------------------------------
  // Signature and calibration bytes
  // ----------------------------------------
  flcs_sig_rom #(
    .SIG0    (SIG0),
    .SIG1    (SIG1),
    .SIG2    (SIG2),
    .CAL_9M6 (CAL_9M6),
    .CAL_4M8 (CAL_4M8)
  ) u_rom (
    .space_i (rom_space),
    .addr_i  (boot_pending ? `FLCS_CAL_9M6 : cmd_addr_i),
    .data_o  (rom_data),
    .hit_o   (rom_hit)
  );
  // ----------------------------------------
  // Firmware read window
  // ----------------------------------------
  flcs_fw_reader u_fw (
    .ref_clk_i   (ref_clk_i),
    .resetn_i    (resetn_i),
    .clk_en_i    (clk_en_i),
    .arm_i       (fw_arm),
    .load_i      (program_memory_load_instr_i),
    .z_addr_i    (fw_z_addr_i),
    .fuse_low_i  (fuse_low),
    .fuse_high_i (fuse_high),
    .lock_byte_i (lock_byte),
    .armed_o     (fw_read_armed_o),
    .valid_o     (fw_read_valid_o),
    .data_o      (fw_read_data_o)
  );
  // ----------------------------------------
  // Programmer commands
  // ----------------------------------------
  // Stored bits model the cells; reset stands in for the
  // shipped state, not for a real power cycle of the cells.
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lock_bits      <= `FLCS_LOCK_RST;
      fuse_low       <= `FLCS_FL_RST;
      fuse_high      <= `FLCS_FH_RST;
      rsp_valid_o    <= 1'b0;
      rsp_data_o     <= 8'h00;
      cmd_refused_o  <= 1'b0;
      flash_erase_o  <= 1'b0;
      eeprom_erase_o <= 1'b0;
      erase_fill_o   <= `FLCS_ERASE_FILL;
    end else if (clk_en_i) begin
      rsp_valid_o    <= 1'b0;
      cmd_refused_o  <= 1'b0;
      flash_erase_o  <= 1'b0;
      eeprom_erase_o <= 1'b0;
      if (cmd_go) begin
        case (cmd_op_i)
          `FLCS_OP_WR_LOCK: begin
            // Writes can only program, never clear
            lock_bits <= lock_bits & cmd_data_i[1:0];
          end
          `FLCS_OP_WR_FL: begin
            if (!lock_bit_low)
              cmd_refused_o <= 1'b1;
            else if (prog_serial_i)
              fuse_low <= {fuse_low[`FLCS_FL_SER],
                           cmd_data_i[`FLCS_FL_SER-1:0]};
            else
              fuse_low <= cmd_data_i;
          end
          `FLCS_OP_WR_FH: begin
            if (!lock_bit_low)
              cmd_refused_o <= 1'b1;
            else
              fuse_high <= cmd_data_i | `FLCS_FH_UNUSED;
          end
          `FLCS_OP_ERASE: begin
            // Fuse bytes deliberately untouched
            lock_bits     <= `FLCS_LOCK_RST;
            flash_erase_o <= 1'b1;
            // Live fuse value, not the latched copy
            eeprom_erase_o <= fuse_low[`FLCS_FL_KEEP];
          end
          `FLCS_OP_RD_FUSE: begin
            rsp_valid_o <= 1'b1;
            if (cmd_addr_i == `FLCS_SEL_FL)
              rsp_data_o <= fuse_low;
            else if (cmd_addr_i == `FLCS_SEL_LOCK)
              rsp_data_o <= lock_byte;
            else if (cmd_addr_i == `FLCS_SEL_FH)
              rsp_data_o <= fuse_high;
            else begin
              rsp_valid_o   <= 1'b0;
              cmd_refused_o <= 1'b1;
            end
          end
          `FLCS_OP_RD_SIG, `FLCS_OP_RD_CAL: begin
            // Lock state is not consulted here
            rsp_valid_o   <= rom_hit;
            rsp_data_o    <= rom_data;
            cmd_refused_o <= !rom_hit;
          end
          default: begin
            rsp_valid_o <= 1'b0;
          end
        endcase
      end
    end
  end
  // ----------------------------------------
  // Fuse latching and calibration load
  // ----------------------------------------
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prog_mode_q  <= 1'b0;
      boot_pending <= 1'b1;
      fl_lat       <= `FLCS_FL_RST;
      fh_lat       <= `FLCS_FH_RST;
      oscillator_calibration_reg_o <= 8'h00;
    end else if (clk_en_i) begin
      prog_mode_q  <= prog_mode_i;
      boot_pending <= 1'b0;
      if (latch_now) begin
        fl_lat <= fuse_low;
        fh_lat <= fuse_high;
      end
      // Only the 9.6 MHz byte is loaded by hardware
      if (boot_pending)
        oscillator_calibration_reg_o <= rom_data;
      else if (cal_wr_i)
        oscillator_calibration_reg_o <= cal_data_i;
    end
  end
  // ----------------------------------------
  // Protection and configuration outputs
  // ----------------------------------------
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      array_write_allow_o     <= 1'b0;
      array_verify_allow_o    <= 1'b0;
      debug_if_enable_o       <= 1'b0;
      debug_flash_read_o      <= 1'b0;
      watchdog_irq_allow_o    <= 1'b1;
      self_program_enable_o   <= 1'b1;
      brownout_level_o        <= 2'h3;
      ext_reset_disable_o     <= 1'b1;
      serial_prog_enable_o    <= 1'b0;
      eeprom_preserve_o       <= 1'b1;
      watchdog_always_on_o    <= 1'b1;
      clock_divide_by_eight_o <= 1'b0;
      startup_time_o          <= 2'h2;
      clock_source_o          <= 2'h2;
    end else if (clk_en_i) begin
      // Any programmed lock bit stops array writes
      array_write_allow_o  <= prog_mode_i && mode_free;
      array_verify_allow_o <= prog_mode_i && lock_bit_high;
      debug_if_enable_o    <= !fh_lat[`FLCS_FH_DBG]
                              && mode_free;
      // Flash stays visible to debug whatever the locks say
      debug_flash_read_o   <= !fh_lat[`FLCS_FH_DBG];
      watchdog_irq_allow_o <= fl_lat[`FLCS_FL_WDOG];
      self_program_enable_o <= fh_lat[`FLCS_FH_SPM];
      brownout_level_o     <= fh_lat[`FLCS_FH_BOD_HI:`FLCS_FH_BOD_LO];
      ext_reset_disable_o  <= fh_lat[`FLCS_FH_RSTD];
      serial_prog_enable_o <= fl_lat[`FLCS_FL_SER];
      eeprom_preserve_o    <= fuse_low[`FLCS_FL_KEEP];
      watchdog_always_on_o <= fl_lat[`FLCS_FL_WDOG];
      clock_divide_by_eight_o <= fl_lat[`FLCS_FL_CKDIV];
      startup_time_o       <= fl_lat[`FLCS_FL_SUT_HI:`FLCS_FL_SUT_LO];
      clock_source_o       <= fl_lat[`FLCS_FL_CKS_HI:`FLCS_FL_CKS_LO];
    end
  end
  // ----------------------------------------
  // Page geometry
  // ----------------------------------------
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flash_word_in_page_o  <= 4'h0;
      flash_page_number_o   <= 5'h00;
      eeprom_byte_in_page_o <= 2'h0;
      eeprom_page_number_o  <= 4'h0;
    end else if (clk_en_i) begin
      flash_word_in_page_o <= flash_addr_i[`FLCS_FLASH_PLSB-1:0];
      flash_page_number_o  <=
        flash_addr_i[`FLCS_FLASH_TOP:`FLCS_FLASH_PLSB];
      eeprom_byte_in_page_o <= eeprom_addr_i[`FLCS_EE_PLSB-1:0];
      eeprom_page_number_o  <=
        eeprom_addr_i[`FLCS_EE_TOP:`FLCS_EE_PLSB];
    end
  end
endmodule // flcs_top
`default_nettype wire

/* pkg/flcs_defs.vh */
// Constants for the fuse, lock and calibration store.
// Assumes one 100 MHz clock; included by bare name from core files.
`ifndef FLCS_DEFS_VH
`define FLCS_DEFS_VH
// ----------------------------------------
// Lock byte
// ----------------------------------------
`define FLCS_LOCK_RST   2'h3
`define FLCS_LOCK_PAD   6'h3F
`define FLCS_LOCK_HI    1
`define FLCS_LOCK_LO    0
// ----------------------------------------
// Fuse bytes
// ----------------------------------------
`define FLCS_FH_RST     8'hFF
`define FLCS_FH_UNUSED  8'hE0
`define FLCS_FL_RST     8'h6A
`define FLCS_FH_SPM     4
`define FLCS_FH_DBG     3
`define FLCS_FH_BOD_HI  2
`define FLCS_FH_BOD_LO  1
`define FLCS_FH_RSTD    0
`define FLCS_FL_SER     7
`define FLCS_FL_KEEP    6
`define FLCS_FL_WDOG    5
`define FLCS_FL_CKDIV   4
`define FLCS_FL_SUT_HI  3
`define FLCS_FL_SUT_LO  2
`define FLCS_FL_CKS_HI  1
`define FLCS_FL_CKS_LO  0
// ----------------------------------------
// Programmer commands and address spaces
// ----------------------------------------
`define FLCS_OP_NOP     3'h0
`define FLCS_OP_WR_LOCK 3'h1
`define FLCS_OP_WR_FL   3'h2
`define FLCS_OP_WR_FH   3'h3
`define FLCS_OP_ERASE   3'h4
`define FLCS_OP_RD_FUSE 3'h5
`define FLCS_OP_RD_SIG  3'h6
`define FLCS_OP_RD_CAL  3'h7
`define FLCS_SEL_FL     2'h0
`define FLCS_SEL_LOCK   2'h1
`define FLCS_SEL_FH     2'h3
`define FLCS_SP_SIG     1'b0
`define FLCS_SP_CAL     1'b1
`define FLCS_CAL_9M6    2'h0
`define FLCS_Z_FL       16'h0000
`define FLCS_Z_LOCK     16'h0001
`define FLCS_Z_FH       16'h0003
`define FLCS_FW_WIN     2'h3
`define FLCS_ERASE_FILL 8'hFF
// ----------------------------------------
// Memory geometry
// ----------------------------------------
`define FLCS_FLASH_TOP  8
`define FLCS_FLASH_PLSB 4
`define FLCS_EE_TOP     5
`define FLCS_EE_PLSB    2
`endif

/* core/flcs_sig_rom.v */
// Signature and oscillator calibration bytes, combinational lookup.
// Assumes the caller registers the result.
`timescale 1ns/10ps
`default_nettype none
`include "flcs_defs.vh"
module flcs_sig_rom #(
  parameter [7:0] SIG0    = 8'hA5, // Arbitrary identity value
  parameter [7:0] SIG1    = 8'h5A, // Arbitrary identity value
  parameter [7:0] SIG2    = 8'h3C, // Arbitrary identity value
  parameter [7:0] CAL_9M6 = 8'h80,
  parameter [7:0] CAL_4M8 = 8'h80
) (
  input  wire       space_i,
  input  wire [1:0] addr_i,
  output reg  [7:0] data_o,
  output reg        hit_o
);
  always @* begin
    data_o = 8'h00;
    hit_o  = 1'b1;
    if (space_i == `FLCS_SP_SIG) begin
      case (addr_i)
        2'h0:    data_o = SIG0;
        2'h1:    data_o = SIG1;
        2'h2:    data_o = SIG2;
        default: hit_o  = 1'b0;
      endcase
    end else begin
      case (addr_i)
        2'h0:    data_o = CAL_9M6;
        2'h1:    data_o = CAL_4M8;
        default: hit_o  = 1'b0;
      endcase
    end
  end
endmodule // flcs_sig_rom
`default_nettype wire

/* core/flcs_fw_reader.v */
// Firmware fuse and lock read window.
// Assumes request and load are single-cycle strobes from the core.
`timescale 1ns/10ps
`default_nettype none
`include "flcs_defs.vh"
module flcs_fw_reader (
  input  wire        ref_clk_i,
  input  wire        resetn_i,
  input  wire        clk_en_i,
  input  wire        arm_i,
  input  wire        load_i,
  input  wire [15:0] z_addr_i,
  input  wire [7:0]  fuse_low_i,
  input  wire [7:0]  fuse_high_i,
  input  wire [7:0]  lock_byte_i,
  output reg         armed_o,
  output reg         valid_o,
  output reg  [7:0]  data_o
);
  reg [1:0] left;
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      armed_o <= 1'b0;
      valid_o <= 1'b0;
      data_o  <= 8'h00;
      left    <= 2'h0;
    end else if (clk_en_i) begin
      valid_o <= 1'b0;
      if (arm_i) begin
        armed_o <= 1'b1;
        left    <= `FLCS_FW_WIN;
      end else if (armed_o && load_i) begin
        armed_o <= 1'b0;
        valid_o <= 1'b1;
        if (z_addr_i == `FLCS_Z_FL)
          data_o <= fuse_low_i;
        else if (z_addr_i == `FLCS_Z_LOCK)
          data_o <= lock_byte_i;
        else if (z_addr_i == `FLCS_Z_FH)
          data_o <= fuse_high_i;
        else
          data_o <= 8'h00;
      end else if (armed_o) begin
        left <= left - 2'h1;
        if (left == 2'h1)
          armed_o <= 1'b0; // Window lapsed unused
      end
    end
  end
endmodule // flcs_fw_reader
`default_nettype wire

/* sim/flcs_top_properties.sv */
// Checker for the fuse, lock and calibration store top level.
// Assumes one clock domain; bound to every flcs_top instance.
`timescale 1ns/10ps
`default_nettype none
module flcs_top_properties #(
  parameter FLASH_AW = 9,
  parameter EE_AW    = 6
) (
  input wire logic                ref_clk_i,
  input wire logic                resetn_i,
  input wire logic                clk_en_i,
  input wire logic                prog_mode_i,
  input wire logic                cmd_valid_i,
  input wire logic [2:0]          cmd_op_i,
  input wire logic                fuse_read_request_i,
  input wire logic                self_program_enable_i,
  input wire logic                program_memory_load_instr_i,
  input wire logic [FLASH_AW-1:0] flash_addr_i,
  input wire logic [EE_AW-1:0]    eeprom_addr_i,
  input wire logic                rsp_valid_o,
  input wire logic                cmd_refused_o,
  input wire logic                flash_erase_o,
  input wire logic                eeprom_erase_o,
  input wire logic [7:0]          erase_fill_o,
  input wire logic                array_write_allow_o,
  input wire logic                array_verify_allow_o,
  input wire logic                debug_if_enable_o,
  input wire logic                debug_flash_read_o,
  input wire logic                watchdog_irq_allow_o,
  input wire logic                watchdog_always_on_o,
  input wire logic                fw_read_armed_o,
  input wire logic                fw_read_valid_o,
  input wire logic [3:0]          flash_word_in_page_o,
  input wire logic [4:0]          flash_page_number_o,
  input wire logic [1:0]          eeprom_byte_in_page_o,
  input wire logic [3:0]          eeprom_page_number_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_cmd(op);
    clk_en_i && prog_mode_i && cmd_valid_i && cmd_op_i == op;
  endsequence
  sequence s_arm;
    clk_en_i && fuse_read_request_i && self_program_enable_i;
  endsequence
  sequence s_idle;
    !(fuse_read_request_i && self_program_enable_i) && !program_memory_load_instr_i;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_erase_fill: assert property (erase_fill_o == 8'hFF)
    else $error("erase fill value wrong");
  a_erase_pulse: assert property (s_cmd(3'h4) |=> flash_erase_o)
    else $error("chip erase gave no flash erase");
  a_erase_ee_pair: assert property (eeprom_erase_o |-> flash_erase_o)
    else $error("eeprom erase without flash erase");
  a_read_answer: assert property ((clk_en_i && prog_mode_i && cmd_valid_i && cmd_op_i[2]
    && cmd_op_i != 3'h4) |=> (rsp_valid_o != cmd_refused_o))
    else $error("read gave no single answer");
  a_erase_unlocks: assert property (s_cmd(3'h4) ##1 prog_mode_i[*2] |-> array_write_allow_o)
    else $error("erase left arrays locked");
  a_write_needs_verify: assert property (array_write_allow_o |-> array_verify_allow_o)
    else $error("write allowed while verify blocked");
  a_debug_needs_fuse: assert property (debug_if_enable_o |-> debug_flash_read_o)
    else $error("debug enabled without debug fuse");
  a_wdt_irq_off: assert property (watchdog_irq_allow_o == watchdog_always_on_o)
    else $error("watchdog interrupt not tied to fuse");
  a_fw_load_answer: assert property ((clk_en_i && fw_read_armed_o
    && program_memory_load_instr_i && !fuse_read_request_i) |=> fw_read_valid_o)
    else $error("armed load gave no data");
  a_fw_valid_cause: assert property (fw_read_valid_o |->
    $past(fw_read_armed_o) && $past(program_memory_load_instr_i))
    else $error("firmware data without armed load");
  a_fw_arm_expiry: assert property (s_arm ##1 s_idle[*3] |=> !fw_read_armed_o)
    else $error("firmware read window too long");
  a_flash_split: assert property (clk_en_i |=>
    {flash_page_number_o, flash_word_in_page_o} == $past(flash_addr_i))
    else $error("flash page split wrong");
  a_ee_split: assert property (clk_en_i |=>
    {eeprom_page_number_o, eeprom_byte_in_page_o} == $past(eeprom_addr_i))
    else $error("eeprom page split wrong");
endmodule // flcs_top_properties
bind flcs_top flcs_top_properties #(.FLASH_AW(FLASH_AW), .EE_AW(EE_AW)) u_props (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
  .prog_mode_i(prog_mode_i), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
  .fuse_read_request_i(fuse_read_request_i), .self_program_enable_i(self_program_enable_i),
  .program_memory_load_instr_i(program_memory_load_instr_i), .flash_addr_i(flash_addr_i),
  .eeprom_addr_i(eeprom_addr_i), .rsp_valid_o(rsp_valid_o), .cmd_refused_o(cmd_refused_o),
  .flash_erase_o(flash_erase_o), .eeprom_erase_o(eeprom_erase_o), .erase_fill_o(erase_fill_o),
  .array_write_allow_o(array_write_allow_o), .array_verify_allow_o(array_verify_allow_o),
  .debug_if_enable_o(debug_if_enable_o), .debug_flash_read_o(debug_flash_read_o),
  .watchdog_irq_allow_o(watchdog_irq_allow_o), .watchdog_always_on_o(watchdog_always_on_o),
  .fw_read_armed_o(fw_read_armed_o), .fw_read_valid_o(fw_read_valid_o),
  .flash_word_in_page_o(flash_word_in_page_o), .flash_page_number_o(flash_page_number_o),
  .eeprom_byte_in_page_o(eeprom_byte_in_page_o), .eeprom_page_number_o(eeprom_page_number_o)
);
`default_nettype wire

/* sim/flcs_prog_model.sv */
// External programmer model: mode levels and one-cycle command strobes.
// Assumes the bench calls its tasks; all changes land on falling edges.
`timescale 1ns/10ps
`default_nettype none
module flcs_prog_model (
  input  wire logic       clk_i,
  output var  logic       prog_mode_o,
  output var  logic       prog_serial_o,
  output var  logic       cmd_valid_o,
  output var  logic [2:0] cmd_op_o,
  output var  logic [1:0] cmd_addr_o,
  output var  logic [7:0] cmd_data_o
);
  initial begin
    prog_mode_o = 1'b0;
    prog_serial_o = 1'b1;
    cmd_valid_o = 1'b0;
    cmd_op_o = 3'h0;
    cmd_addr_o = 2'h0;
    cmd_data_o = 8'h00;
  end
  // High-voltage mode is picked before touching the reset disable fuse
  task automatic mode(input logic m, input logic serial);
    @(negedge clk_i);
    prog_mode_o = m;
    prog_serial_o = serial;
  endtask
  task automatic issue(input logic [2:0] op, input logic [1:0] a, input logic [7:0] d);
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_op_o = op;
    cmd_addr_o = a;
    cmd_data_o = d;
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    // Released lines flip so stale data cannot pass for a match
    cmd_addr_o = ~a;
    cmd_data_o = ~d;
  endtask
endmodule // flcs_prog_model
`default_nettype wire

/* sim/flcs_top_bench.sv */
// Self-checking bench for the fuse, lock and calibration store.
// Assumes the programmer model and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module flcs_top_bench;
  localparam [7:0] CAL_A = 8'h5C;
  localparam [7:0] CAL_B = 8'hA3;
  localparam [7:0] SG0 = 8'h21; // Arbitrary identity value
  localparam [7:0] SG1 = 8'h43; // Arbitrary identity value
  localparam [7:0] SG2 = 8'h65; // Arbitrary identity value
  logic ref_clk_i, resetn_i, fw_req, fw_spm, fw_load, osc_wr;
  logic [15:0] fw_z;
  logic [7:0]  osc_d;
  logic [8:0]  fa;
  logic [5:0]  ea;
  int          errors, cmp_count;
  logic [2:0]  t_op [8] = '{3'h5, 3'h5, 3'h5, 3'h6, 3'h6, 3'h6, 3'h7, 3'h7};
  logic [1:0]  t_ad [8] = '{2'h0, 2'h1, 2'h3, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1};
  logic [7:0]  t_ex [8] = '{8'h6A, 8'hFF, 8'hFF, SG0, SG1, SG2, CAL_A, CAL_B};
  wire pm, ps, cv, rsp_valid, refused, f_er, e_er, w_ok, v_ok, dbg_if, dbg_rd, wdt_irq;
  wire spm, rst_dis, spi_en, ee_keep, wdt_on, ckdiv, fw_valid;
  wire [2:0] cop;
  wire [1:0] cad, bod, sut, cks, ebyte;
  wire [7:0] cdat, rsp_data, fill, osc, fw_data;
  wire [3:0] fword, epage;
  wire [4:0] fpage;
  flcs_prog_model prog (.clk_i(ref_clk_i), .prog_mode_o(pm), .prog_serial_o(ps),
    .cmd_valid_o(cv), .cmd_op_o(cop), .cmd_addr_o(cad), .cmd_data_o(cdat));
  flcs_top #(.SIG0(SG0), .SIG1(SG1), .SIG2(SG2), .CAL_9M6(CAL_A), .CAL_4M8(CAL_B)) uut (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .clk_en_i(1'b1), .prog_mode_i(pm),
    .prog_serial_i(ps), .cmd_valid_i(cv), .cmd_op_i(cop), .cmd_addr_i(cad), .cmd_data_i(cdat),
    .fuse_read_request_i(fw_req), .self_program_enable_i(fw_spm),
    .program_memory_load_instr_i(fw_load), .fw_z_addr_i(fw_z), .cal_wr_i(osc_wr),
    .cal_data_i(osc_d), .flash_addr_i(fa), .eeprom_addr_i(ea), .rsp_valid_o(rsp_valid),
    .rsp_data_o(rsp_data), .cmd_refused_o(refused), .flash_erase_o(f_er),
    .eeprom_erase_o(e_er), .erase_fill_o(fill), .array_write_allow_o(w_ok),
    .array_verify_allow_o(v_ok), .debug_if_enable_o(dbg_if), .debug_flash_read_o(dbg_rd),
    .watchdog_irq_allow_o(wdt_irq), .self_program_enable_o(spm), .brownout_level_o(bod),
    .ext_reset_disable_o(rst_dis), .serial_prog_enable_o(spi_en), .eeprom_preserve_o(ee_keep),
    .watchdog_always_on_o(wdt_on), .clock_divide_by_eight_o(ckdiv), .startup_time_o(sut),
    .clock_source_o(cks), .oscillator_calibration_reg_o(osc), .fw_read_armed_o(),
    .fw_read_valid_o(fw_valid), .fw_read_data_o(fw_data), .flash_word_in_page_o(fword),
    .flash_page_number_o(fpage), .eeprom_byte_in_page_o(ebyte), .eeprom_page_number_o(epage));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic give_verdict;
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [2:0] op, input logic [1:0] a, input logic [7:0] exp);
    prog.issue(op, a, 8'h00);
    chk({7'h00, rsp_valid}, 8'h01);
    chk(rsp_data, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // Gap of three idle cycles puts the load past the three-edge window
  task automatic fw(input logic [15:0] z, input int gap, input logic [7:0] exp, input logic ok);
    @(negedge ref_clk_i);
    fw_req = 1'b1;
    fw_spm = 1'b1;
    @(negedge ref_clk_i);
    fw_req = 1'b0;
    fw_spm = 1'b0;
    settle(gap);
    fw_load = 1'b1;
    fw_z = z;
    @(negedge ref_clk_i);
    fw_load = 1'b0;
    fw_z = ~z;
    chk({7'h00, fw_valid}, {7'h00, ok});
    if (ok) chk(fw_data, exp);
  endtask
  task automatic do_reset;
    resetn_i = 1'b0;
    settle(16);
    resetn_i = 1'b1;
    settle(3);
  endtask
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    errors++;
    give_verdict();
  end
  initial begin
    errors = 0;
    cmp_count = 0;
    {fw_req, fw_spm, fw_load, osc_wr, resetn_i} = 5'h00;
    fw_z = 16'h0000;
    osc_d = 8'h00;
    fa = 9'h000;
    ea = 6'h00;
    do_reset();
    chk(osc, CAL_A);
    chk({cks, sut, ckdiv, wdt_on, ee_keep, spi_en}, 8'hA6);
    chk({3'h0, spm, bod, rst_dis, dbg_rd}, 8'h1E);
    prog.mode(1'b1, 1'b1);
    settle(2);
    for (int i = 0; i < 8; i++) rd(t_op[i], t_ad[i], t_ex[i]);
    prog.issue(3'h5, 2'h2, 8'h00);
    chk({7'h00, refused}, 8'h01);
    prog.issue(3'h4, 2'h0, 8'h00);
    chk({6'h00, f_er, e_er}, 8'h03);
    prog.issue(3'h2, 2'h0, 8'h8A);
    rd(3'h5, 2'h0, 8'h0A);
    settle(2);
    chk({6'h00, wdt_on, ee_keep}, 8'h02);
    prog.mode(1'b1, 1'b0);
    prog.issue(3'h3, 2'h0, 8'hF4);
    rd(3'h5, 2'h3, 8'hF4);
    prog.mode(1'b0, 1'b1);
    settle(3);
    chk({3'h0, wdt_on, wdt_irq, rst_dis, dbg_rd, dbg_if}, 8'h03);
    chk({5'h00, spm, bod}, 8'h06);
    prog.mode(1'b1, 1'b1);
    settle(2);
    prog.issue(3'h1, 2'h0, 8'hFE);
    settle(2);
    chk({4'h0, w_ok, v_ok, dbg_if, dbg_rd}, 8'h05);
    prog.issue(3'h3, 2'h0, 8'hFF);
    chk({7'h00, refused}, 8'h01);
    rd(3'h5, 2'h3, 8'hF4);
    prog.issue(3'h1, 2'h0, 8'hFF);
    rd(3'h5, 2'h1, 8'hFE);
    prog.issue(3'h1, 2'h0, 8'hFC);
    settle(2);
    chk({6'h00, w_ok, v_ok}, 8'h00);
    rd(3'h6, 2'h0, SG0);
    prog.issue(3'h4, 2'h0, 8'h00);
    chk({6'h00, f_er, e_er}, 8'h02);
    settle(2);
    rd(3'h5, 2'h1, 8'hFF);
    chk({6'h00, w_ok, v_ok}, 8'h03);
    rd(3'h5, 2'h0, 8'h0A);
    prog.mode(1'b0, 1'b1);
    settle(3);
    fw(16'h0003, 0, 8'hF4, 1'b1);
    fw(16'h0001, 0, 8'hFF, 1'b1);
    fw(16'h0000, 0, 8'h0A, 1'b1);
    fw(16'h0003, 3, 8'h00, 1'b0);
    @(negedge ref_clk_i);
    osc_wr = 1'b1;
    osc_d = CAL_B;
    fa = 9'h1A7;
    ea = 6'h2D;
    @(negedge ref_clk_i);
    osc_wr = 1'b0;
    osc_d = ~CAL_B;
    chk(osc, CAL_B);
    chk({fpage, fword[3:1]}, 8'hD3);
    chk({2'h0, epage, ebyte}, 8'h2D);
    do_reset();
    chk(osc, CAL_A);
    give_verdict();
  end
endmodule // flcs_top_bench
`default_nettype wire
